// >>> hw/ips_i2c_slave.sv
// Two-wire slave port to the 8-bit configuration registers
// Operation
// - Slave only; never drives the clock, master makes every edge and start.
// - Works for any clock rate from stopped up to 3.4MHz.
// - Transaction opens with START then a 7-bit slave address.
// - Fuse picks main address 0x48 or 0x40; address LSB selects read.
// - No acknowledge for any address but main and unlocked test address.
// - Test address 0x49 acknowledged only while test mode is unlocked.
// - Registers and register pointer are eight bits wide.
// - One data byte written to the register the pointer selects.
// - Multi-byte write stores successive bytes, pointer steps after each.
// - Single read returns the register the pointer selects.
// - Multi-byte read returns successive registers until master ends.
// - Accesses below 0x80 are routed to top, switcher, linear, pin and sink logic.
`timescale 1ns/1ps
`default_nettype none
`include "ips_defines.svh"
module ips_i2c_slave (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Fuse and test mode
  input wire logic addr_fuse_i,
  input wire logic test_unlock_i,
  // Register access
  output ips_pkg::ips_reg_req_t reg_req_o,
  input wire logic [7:0] rd_data_i,
  // Status
  output logic busy_o
);
  import ips_pkg::*;
  localparam int SCL_MIN_CYC = `IPS_SCL_MIN_CYC;

  logic lrstn;
  logic [`IPS_Q_AW:0] wgray;
  logic [`IPS_Q_AW:0] wgray_s;
  logic [(1<<`IPS_Q_AW)-1:0] qmem;
  logic [1:0] line_s;
  logic [1:0] line_d_ff;
  logic [`IPS_Q_AW:0] rptr_ff;
  logic [`IPS_Q_AW:0] wbin;
  logic fuse_ff;
  logic strap_done_ff;
  ips_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic ack_pend_ff;
  logic oe_ff;
  logic sda_o_ff;
  logic wr_ff;
  logic rd_ff;
  logic [7:0] wdata_ff;
  logic [4:0] sel_ff;
  logic busy_ff;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic pop;
  logic qbit;
  logic byte_done;
  logic ack_bit;
  logic [7:0] byte_val;
  logic [6:0] main_addr;
  logic addr_hit;
  logic rd_load;

  // Link side reset follows the system reset on serial clock edges
  ips_sync #(.W(1)) u_lrst (
    .clk_i(scl_i),
    .d_i(rstn_i),
    .q_o(lrstn)
  );

  ips_bitq u_bitq (
    .scl_i(scl_i),
    .lrstn_i(lrstn),
    .sda_i(sda_i),
    .wgray_o(wgray),
    .mem_o(qmem)
  );

  ips_sync #(.W(`IPS_Q_AW + 1)) u_wsync (
    .clk_i(clk_i),
    .d_i(wgray),
    .q_o(wgray_s)
  );

  ips_sync #(.W(2)) u_lsync (
    .clk_i(clk_i),
    .d_i({scl_i, sda_i}),
    .q_o(line_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      line_d_ff <= 2'h3;
    end else begin
      line_d_ff <= line_s;
    end
  end

  // Data edges while the clock stays high
  assign start_det = scl_s && line_d_ff[1] && line_d_ff[0] && !sda_s;
  assign stop_det = scl_s && line_d_ff[1] && !line_d_ff[0] && sda_s;
  assign scl_fall = line_d_ff[1] && !scl_s;

  // Bits captured on the link clock, one popped per cycle
  assign wbin = ips_gray2bin(wgray_s);
  assign pop = (rptr_ff != wbin) && !start_det;
  assign qbit = qmem[rptr_ff[`IPS_Q_AW-1:0]];

  // A start discards bits from before it, so a stray edge cannot shift the frame
  always_ff @(posedge clk_i) begin
    if (!rstn_i || start_det) begin
      rptr_ff <= wbin;
    end else if (pop) begin
      rptr_ff <= rptr_ff + 1'b1;
    end
  end

  // Fuse is sampled once, right after reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fuse_ff <= 1'b0;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      fuse_ff <= addr_fuse_i;
      strap_done_ff <= 1'b1;
    end
  end

  assign main_addr = fuse_ff ? `IPS_ADDR_FUSE_SET : `IPS_ADDR_FUSE_CLR;
  assign byte_val = {rx_ff[6:0], qbit};
  assign addr_hit = (byte_val[7:1] == main_addr) ||
                    (test_unlock_i && byte_val[7:1] == `IPS_ADDR_TEST);
  assign byte_done = pop && bit_cnt_ff == 4'h7;
  assign ack_bit = pop && bit_cnt_ff == 4'h8;
  // Own ack on the address reads back low, so one test covers both cases
  assign rd_load = ack_bit && state_ff == ST_RDATA && !qbit;

  always_ff @(posedge clk_i) begin
    if (!rstn_i || start_det) begin
      bit_cnt_ff <= 4'h0;
    end else if (pop) begin
      bit_cnt_ff <= (bit_cnt_ff == 4'h8) ? 4'h0 : bit_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rx_ff <= 8'h00;
    end else if (pop && bit_cnt_ff < 4'h8) begin
      rx_ff <= byte_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || stop_det) begin
      state_ff <= ST_IDLE;
    end else if (start_det) begin
      state_ff <= ST_ADDR;
    end else if (byte_done) begin
      unique case (state_ff)
        ST_ADDR: state_ff <= !addr_hit ? ST_IGNORE : (byte_val[0] ? ST_RDATA : ST_PTR);
        ST_PTR: state_ff <= ST_WDATA;
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE,
        ST_IDLE: state_ff <= state_ff;
      endcase
    end else if (ack_bit && state_ff == ST_RDATA && qbit) begin
      state_ff <= ST_IGNORE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || start_det || stop_det || ack_bit) begin
      ack_pend_ff <= 1'b0;
    end else if (byte_done) begin
      ack_pend_ff <= (state_ff == ST_ADDR && addr_hit) ||
                     state_ff == ST_PTR || state_ff == ST_WDATA;
    end
  end

  // Pointer survives stop, so a later read starts where it was set
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ptr_ff <= `IPS_PTR_RST;
    end else if (byte_done && state_ff == ST_PTR) begin
      ptr_ff <= byte_val;
    end else if (wr_ff || rd_ff) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      wr_ff <= byte_done && state_ff == ST_WDATA;
      rd_ff <= rd_load;
      if (byte_done && state_ff == ST_WDATA) begin
        wdata_ff <= byte_val;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sel_ff <= 5'h00;
    end else begin
      sel_ff <= ips_decode(ptr_ff);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tx_ff <= 8'h00;
    end else if (rd_load) begin
      tx_ff <= rd_data_i;
    end else if (scl_fall && state_ff == ST_RDATA && bit_cnt_ff < 4'h8) begin
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  // Drive turns on only after a clock fall; start and stop release it while the clock is high
  always_ff @(posedge clk_i) begin
    if (!rstn_i || start_det || stop_det) begin
      oe_ff <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt_ff == 4'h8 && ack_pend_ff) begin
        oe_ff <= 1'b1;
      end else if (state_ff == ST_RDATA && bit_cnt_ff < 4'h8) begin
        oe_ff <= !tx_ff[7];
      end else begin
        oe_ff <= 1'b0;
      end
    end
  end

  // Open drain: only ever pulls low; the clock line has no driver at all
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sda_o_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      sda_o_ff <= 1'b0;
      busy_ff <= state_ff != ST_IDLE;
    end
  end

  assign sda_o = sda_o_ff;
  assign sda_oe_o = oe_ff;
  assign busy_o = busy_ff;
  assign reg_req_o = '{wr: wr_ff, rd: rd_ff, addr: ptr_ff, wdata: wdata_ff, sel: sel_ff};

  // Cycles since the last captured bit, for the clock rate check
  logic [7:0] gap_ff;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gap_ff <= 8'hFF;
    end else if (pop) begin
      gap_ff <= 8'h00;
    end else if (gap_ff != 8'hFF) begin
      gap_ff <= gap_ff + 8'h01;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  property p_slave_drive;
    $rose(sda_oe_o) |-> busy_o && state_ff != ST_IGNORE && !sda_o;
  endproperty
  a_slave_drive: assert property (p_slave_drive) else $error("sda driven outside a transfer");

  property p_rate;
    pop && gap_ff != 8'hFF |-> gap_ff >= 8'(SCL_MIN_CYC - 4);
  endproperty
  a_rate: assert property (p_rate) else $error("bits closer than the clock limit");

  property p_drive_on_fall;
    $changed(sda_oe_o) |-> $past(scl_fall) || $past(start_det) || $past(stop_det);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("sda moved off a clock fall");

  property p_start;
    start_det |=> state_ff == ST_ADDR && bit_cnt_ff == 4'h0 && !sda_oe_o;
  endproperty
  a_start: assert property (p_start) else $error("start did not open address phase");

  property p_main_ack;
    byte_done && state_ff == ST_ADDR && byte_val[7:1] == main_addr |=> ack_pend_ff;
  endproperty
  a_main_ack: assert property (p_main_ack) else $error("main address not acknowledged");

  property p_foreign;
    byte_done && state_ff == ST_ADDR && !addr_hit |=> state_ff == ST_IGNORE && !ack_pend_ff;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address acknowledged");

  property p_test_locked;
    byte_done && state_ff == ST_ADDR && byte_val[7:1] == `IPS_ADDR_TEST &&
    byte_val[7:1] != main_addr && !test_unlock_i |=> state_ff == ST_IGNORE;
  endproperty
  a_test_locked: assert property (p_test_locked) else $error("test address taken while locked");

  property p_ptr_load;
    byte_done && state_ff == ST_PTR |=> ptr_ff == $past(byte_val) && state_ff == ST_WDATA;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not stored");

  property p_write;
    byte_done && state_ff == ST_WDATA |=> reg_req_o.wr && reg_req_o.wdata == $past(byte_val);
  endproperty
  a_write: assert property (p_write) else $error("data byte not written");

  property p_step;
    reg_req_o.wr || reg_req_o.rd |=> reg_req_o.addr == 8'($past(reg_req_o.addr) + 1);
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step");

  property p_read;
    rd_load |=> reg_req_o.rd && tx_ff == $past(rd_data_i);
  endproperty
  a_read: assert property (p_read) else $error("read data not taken");

  property p_route;
    reg_req_o.wr || reg_req_o.rd |-> reg_req_o.sel == ips_decode(reg_req_o.addr);
  endproperty
  a_route: assert property (p_route) else $error("access routed to wrong target");

  property p_ack_drive;
    scl_fall && bit_cnt_ff == 4'h8 && ack_pend_ff && !start_det && !stop_det |=> sda_oe_o;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

  property p_nack_end;
    ack_bit && state_ff == ST_RDATA && qbit && !start_det |=> state_ff == ST_IGNORE ##1 !rd_ff;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("read went on after nack");

  property p_read_addr;
    byte_done && state_ff == ST_ADDR && addr_hit && byte_val[0] |=> state_ff == ST_RDATA;
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("read address did not enter read");

  c_write: cover property (reg_req_o.wr ##[1:600] reg_req_o.wr);
  c_read: cover property (reg_req_o.rd ##[1:600] reg_req_o.rd);
  c_nack: cover property (ack_bit && state_ff == ST_RDATA && qbit);
  c_test: cover property (byte_done && state_ff == ST_ADDR && byte_val[7:1] == `IPS_ADDR_TEST);
endmodule // ips_i2c_slave
`default_nettype wire

// >>> hw/ips_defines.svh
// Constants of the serial register port
`ifndef IPS_DEFINES_SVH
`define IPS_DEFINES_SVH

// Slave addresses, 7 bit
`define IPS_ADDR_FUSE_SET 7'h48
`define IPS_ADDR_FUSE_CLR 7'h40
`define IPS_ADDR_TEST 7'h49

// Register pointer after reset
`define IPS_PTR_RST 8'h00

// Target windows of the register space, upper bound exclusive
`define IPS_TOP_END 8'h20
`define IPS_SIMO_END 8'h40
`define IPS_LDO_END 8'h50
`define IPS_GPIO_END 8'h60
`define IPS_SINK_END 8'h80

// Target select bit positions
`define IPS_SEL_TOP 0
`define IPS_SEL_SIMO 1
`define IPS_SEL_LDO 2
`define IPS_SEL_GPIO 3
`define IPS_SEL_SINK 4

// Serial clock limit and the system clock
`define IPS_SCL_MAX_KHZ 3400
`define IPS_CLK_KHZ 200000
`define IPS_SCL_MIN_CYC ((`IPS_CLK_KHZ + `IPS_SCL_MAX_KHZ - 1) / `IPS_SCL_MAX_KHZ)

// Bit queue index width, pointers are one bit wider; depth is two to this power
`define IPS_Q_AW 2

`endif

// >>> hw/ips_pkg.sv
// Types and helpers of the serial register port
package ips_pkg;
  `include "ips_defines.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGNORE = 3'b101
  } ips_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [4:0] sel;
  } ips_reg_req_t;

  function automatic logic [`IPS_Q_AW:0] ips_bin2gray(input logic [`IPS_Q_AW:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [`IPS_Q_AW:0] ips_gray2bin(input logic [`IPS_Q_AW:0] g);
    logic [`IPS_Q_AW:0] b;
    b = g;
    for (int i = `IPS_Q_AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [4:0] ips_decode(input logic [7:0] a);
    logic [4:0] s;
    s = 5'h00;
    if (a < `IPS_TOP_END) s[`IPS_SEL_TOP] = 1'b1;
    else if (a < `IPS_SIMO_END) s[`IPS_SEL_SIMO] = 1'b1;
    else if (a < `IPS_LDO_END) s[`IPS_SEL_LDO] = 1'b1;
    else if (a < `IPS_GPIO_END) s[`IPS_SEL_GPIO] = 1'b1;
    else if (a < `IPS_SINK_END) s[`IPS_SEL_SINK] = 1'b1;
    return s;
  endfunction
endpackage

// >>> hw/ips_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ips_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk_i,
  // Level in and out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    meta_ff <= d_i;
    sync_ff <= meta_ff;
  end

  assign q_o = sync_ff;
endmodule // ips_sync
`default_nettype wire

// >>> hw/ips_bitq.sv
// Serial clock domain: data bit capture with a gray write pointer
`timescale 1ns/1ps
`default_nettype none
`include "ips_defines.svh"
module ips_bitq (
  // Link clock and its reset
  input wire logic scl_i,
  input wire logic lrstn_i,
  // Data line
  input wire logic sda_i,
  // Towards the system domain
  output logic [`IPS_Q_AW:0] wgray_o,
  output logic [(1<<`IPS_Q_AW)-1:0] mem_o
);
  import ips_pkg::*;

  logic [`IPS_Q_AW:0] wptr_ff;
  logic [`IPS_Q_AW:0] wgray_ff;
  logic [(1<<`IPS_Q_AW)-1:0] mem_ff;
  logic [`IPS_Q_AW:0] nxt_wptr;

  assign nxt_wptr = wptr_ff + 1'b1;

  // Bit is stored on the same clock edge that moves the pointer announcing it
  always_ff @(posedge scl_i) begin
    if (!lrstn_i) begin
      wptr_ff <= '0;
      wgray_ff <= '0;
    end else begin
      mem_ff[wptr_ff[`IPS_Q_AW-1:0]] <= sda_i;
      wptr_ff <= nxt_wptr;
      wgray_ff <= ips_bin2gray(nxt_wptr);
    end
  end

  assign wgray_o = wgray_ff;
  assign mem_o = mem_ff;
endmodule // ips_bitq
`default_nettype wire

// >>> tb/ips_mst_model.sv
// Two-wire bus master model driving the serial clock and data
`timescale 1ns/1ps
`default_nettype none
module ips_mst_model (
  // Wire level seen back
  input wire logic sda_w_i,
  // Driven lines, 1 = released to the pull-up
  output logic scl_o,
  output logic sda_o
);
  // Quarter bit; odd value keeps edges drifting against the system clock
  real q_ns = 75.3;
  logic r_v;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Clock pulses with data released, no START
  task automatic pulses(input int n);
    repeat (n) begin
      #(2 * q_ns) scl_o = 1'b0;
      #(2 * q_ns) scl_o = 1'b1;
    end
  endtask
  // One bit; the clock is ours alone, the slave only watches it
  task automatic bit_io(input logic b, output logic r);
    #(q_ns) sda_o = b;
    #(q_ns) scl_o = 1'b1;
    #(q_ns) r = sda_w_i;
    #(q_ns) scl_o = 1'b0;
  endtask
  // Works from idle and as a repeated start; three quarters of a bit kept before the rise
  task automatic start();
    #(q_ns) sda_o = 1'b1;
    #(2 * q_ns) scl_o = 1'b1;
    #(q_ns) sda_o = 1'b0;
    #(q_ns) scl_o = 1'b0;
  endtask
  // Leaves the clock standing high between frames
  task automatic stop();
    #(q_ns) sda_o = 1'b0;
    #(q_ns) scl_o = 1'b1;
    #(q_ns) sda_o = 1'b1;
    #(q_ns);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r_v);
    bit_io(1'b1, r_v);
    ack = ~r_v;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, r_v);
  endtask
endmodule // ips_mst_model
`default_nettype wire

// >>> tb/test_i2c_register_slave_port.sv
// Self-checking bench of the two-wire register slave port
`timescale 1ns/1ps
`default_nettype none
`define IPS_CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((e) !== (g)) begin \
      err_total++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
    end \
  end
module test_i2c_register_slave_port;
  import ips_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic addr_fuse_i = 1'b1;
  logic test_unlock_i = 1'b0;
  logic scl_i;
  logic sda_i;
  logic m_sda;
  logic sda_o;
  logic sda_oe_o;
  logic busy_o;
  logic [7:0] rd_data_i;
  ips_reg_req_t reg_req_o;
  logic [7:0] regs [256];
  logic [7:0] mdl [256];
  logic [7:0] bnd [6] = '{8'h1E, 8'h3E, 8'h4E, 8'h5E, 8'h7E, 8'hFF};
  logic [15:0] wq [$];
  logic [15:0] exp_w;
  logic [6:0] main_a;
  logic [7:0] b_v;
  logic ack_v;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int rd_cnt = 0;
  int ptr = 0;
  // Open drain: pulled low by either party, else the pull-up wins
  assign sda_i = m_sda & ((sda_oe_o === 1'b1) ? sda_o : 1'b1);
  assign rd_data_i = regs[reg_req_o.addr];
  ips_i2c_slave dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_fuse_i(addr_fuse_i),
    .test_unlock_i(test_unlock_i), .reg_req_o(reg_req_o), .rd_data_i(rd_data_i),
    .busy_o(busy_o));
  ips_mst_model m_u (.sda_w_i(sda_i), .scl_o(scl_i), .sda_o(m_sda));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [4:0] exp_sel(input logic [7:0] a);
    if (a < 8'h20) return 5'h01;
    if (a < 8'h40) return 5'h02;
    if (a < 8'h50) return 5'h04;
    if (a < 8'h60) return 5'h08;
    return (a < 8'h80) ? 5'h10 : 5'h00;
  endfunction
  function automatic logic acked(input logic [6:0] a);
    return (a == main_a) || (a == 7'h49 && test_unlock_i);
  endfunction
  // Target side on the falling edge, so strobes are settled when looked at
  always @(negedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_total++;
      finish_test();
    end
    if (reg_req_o.wr === 1'b1) begin
      regs[reg_req_o.addr] <= reg_req_o.wdata;
      exp_w = (wq.size() > 0) ? wq.pop_front() : 16'hXXXX;
      `IPS_CHK("write", exp_w, {reg_req_o.addr, reg_req_o.wdata})
      `IPS_CHK("sel", exp_sel(reg_req_o.addr), reg_req_o.sel)
    end
    if (reg_req_o.rd === 1'b1) rd_cnt++;
  end
  task automatic open_t(input logic [6:0] a, input logic rw, output logic ack);
    m_u.start();
    `IPS_CHK("busy", 1'b1, busy_o)
    m_u.wr_byte({a, rw}, ack);
    `IPS_CHK("addr ack", acked(a), ack)
  endtask
  task automatic close_t(input int n_ptr);
    m_u.stop();
    repeat (12) @(negedge clk_i);
    `IPS_CHK("idle", 1'b0, busy_o)
    `IPS_CHK("writes left", 0, wq.size())
    `IPS_CHK("pointer", n_ptr[7:0], reg_req_o.addr)
  endtask
  task automatic do_write(input logic [6:0] a, input logic [7:0] p, input int n);
    logic [7:0] d;
    open_t(a, 1'b0, ack_v);
    if (ack_v === 1'b1) begin
      m_u.wr_byte(p, ack_v);
      `IPS_CHK("ptr ack", 1'b1, ack_v)
      ptr = p;
      for (int i = 0; i < n; i++) begin
        d = 8'($urandom);
        wq.push_back({ptr[7:0], d});
        mdl[ptr] = d;
        ptr = (ptr + 1) % 256;
        m_u.wr_byte(d, ack_v);
        `IPS_CHK("data ack", 1'b1, ack_v)
      end
    end
    close_t(ptr);
  endtask
  // Negative pointer: read from the retained pointer, no pointer write
  task automatic do_read(input logic [6:0] a, input int p, input int n);
    int r0;
    if (p >= 0) begin
      open_t(a, 1'b0, ack_v);
      m_u.wr_byte(p[7:0], ack_v);
      `IPS_CHK("ptr ack", 1'b1, ack_v)
      ptr = p;
    end
    r0 = rd_cnt;
    open_t(a, 1'b1, ack_v);
    for (int i = 0; i < n; i++) begin
      m_u.rd_byte(i < n - 1, b_v);
      `IPS_CHK("read data", mdl[ptr], b_v)
      ptr = (ptr + 1) % 256;
    end
    close_t(ptr);
    `IPS_CHK("read strobes", n, rd_cnt - r0)
  endtask
  initial begin
    void'($urandom(32'hCDEA));
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'($urandom);
      mdl[i] = regs[i];
    end
    // Both fuse settings, the second reset lands mid-run
    for (int f = 1; f >= 0; f--) begin
      @(negedge clk_i);
      rstn_i = 1'b0;
      addr_fuse_i = f[0];
      test_unlock_i = 1'b0;
      m_u.pulses(3);
      repeat (16) @(negedge clk_i);
      rstn_i = 1'b1;
      ptr = 0;
      main_a = f[0] ? 7'h48 : 7'h40;
      m_u.q_ns = f[0] ? 75.3 : 100.3;
      repeat (4) @(negedge clk_i);
      `IPS_CHK("reset ptr", 8'h00, reg_req_o.addr)
      `IPS_CHK("reset oe", 1'b0, sda_oe_o)
      `IPS_CHK("reset sda", 1'b0, sda_o)
      `IPS_CHK("reset busy", 1'b0, busy_o)
      // Link side leaves reset only on serial clock edges
      m_u.pulses(2);
      do_write(main_a, 8'($urandom), 1);
      foreach (bnd[k]) do_write(main_a, bnd[k], 2);
      do_read(main_a, $urandom % 128, 1);
      do_read(main_a, 8'h4E, 4);
      do_read(main_a, -1, 2);
      do_write(main_a ^ 7'h08, 8'h10, 1);
      do_write(7'h49, 8'h11, 1);
      do_write(7'($urandom), 8'h12, 1);
      @(negedge clk_i);
      test_unlock_i = 1'b1;
      do_write(7'h49, 8'h13, 2);
      do_read(7'h49, 8'h13, 2);
    end
    finish_test();
  end
endmodule // test_i2c_register_slave_port
`default_nettype wire
